/* hw/fbrc_ctrl.sv */
`timescale 1ns/1ps
// How it works
// - flash modes: parallel programmer, serial programmer, cpu self-rewrite
// - reset with mode-select pin low starts from user program area
// - boot strap pattern at reset starts boot area via fffc/fffd vector
// - boot area program may rewrite the user program area
// - boot area program/erase only in parallel programmer mode
// - boot area erases as one 4k byte block
// - block erase names its block by the highest address
// - program/erase start by software command; bytes programmed, blocks erased
// - read-out protection available in both programmer modes
// - self-rewrite reachable from single-chip and boot mode
// - control bit 1 set enters self-rewrite; commands then accepted
// - self-rewrite may only touch user area, never boot area
// - in self-rewrite cpu may not read the flash array directly
// - readable status reports normal end or error of last operation
// - select bit sets only by zero then one write; zero clears
// - control bit 0 reads zero while busy, one otherwise
// - bit 3 holds flash control in reset until written zero
// - bit 6 flags program failure, bit 7 flags erase failure
module fbrc_ctrl
   import fbrc_pkg::*;
(
   input  wire logic         clk_i,
   input  wire logic         rst_b_i,
   input  wire logic [11:0]  avs_address_i,
   input  wire logic         avs_read_i,
   input  wire logic         avs_write_i,
   input  wire logic [31:0]  avs_writedata_i,
   input  wire logic [3:0]   avs_byteenable_i,
   output logic [31:0]       avs_readdata_o,
   output logic              avs_waitrequest_o,
   input  wire fbrc_strap_t  strap_i,
   input  wire logic         par_prog_mode_i,
   input  wire logic         ser_prog_mode_i,
   input  wire logic         cpu_rd_i,
   input  wire logic [15:0]  cpu_addr_i,
   output logic              cpu_ack_o,
   output logic [7:0]        cpu_rdata_o,
   output logic              cpu_rd_err_o,
   output logic              boot_mode_o,
   output logic [15:0]       start_vec_o,
   output logic              start_vec_valid_o,
   output logic              flash_ready_flag_o,
   output logic              irq_o
);

   fbrc_state_t            st_ff, nxt_st;
   fbrc_fmode_t            fmode;
   fbrc_mem_req_t          mreq;
   logic [7:0]             mrdata;
   logic                   ack_ff;
   logic [31:0]            rdata_ff;
   logic                   sel_ff, armed_ff, frst_ff;
   logic                   perr_ff, eerr_ff, prot_ff;
   logic                   boot_mode_ff, vec_valid_ff;
   logic [15:0]            vec_ff;
   logic [16:0]            addr_ff;
   logic [7:0]             data_ff;
   logic                   op_boot_ff;
   logic [15:0]            op_addr_ff;
   logic [7:0]             op_data_ff;
   logic [12:0]            cnt_ff, nxt_cnt;
   logic [FBRC_IRQ_W-1:0]  irq_st_ff, irq_en_ff;
   logic                   cpu_pend_ff, cpu_epend_ff;
   logic                   cpu_ack_ff, cpu_err_ff;
   logic [7:0]             cpu_rdata_ff;

   // ---------------------------------------------------------------
   // bus decode: one wait state, so read data stand at the accept edge
   // ---------------------------------------------------------------
   wire        bus_req = avs_read_i | avs_write_i;
   wire        wr_acc  = avs_write_i & ack_ff;
   wire        rd_go   = avs_read_i & ~ack_ff;
   wire [31:0] wd      = avs_writedata_i;
   wire [3:0]  be      = avs_byteenable_i;
   wire        hit_c0  = avs_address_i == FBRC_OFS_CTRL0;
   wire        hit_cmd = avs_address_i == FBRC_OFS_CMD;
   wire        hit_adr = avs_address_i == FBRC_OFS_ADDR;
   wire        hit_dat = avs_address_i == FBRC_OFS_DATA;
   wire        hit_md  = avs_address_i == FBRC_OFS_MODE;
   wire        hit_ist = avs_address_i == FBRC_OFS_IRQ_ST;
   wire        hit_ien = avs_address_i == FBRC_OFS_IRQ_EN;
   wire        hit_icl = avs_address_i == FBRC_OFS_IRQ_CLR;
   wire        wr_c0   = wr_acc & hit_c0 & be[0];
   wire        wr_cmd  = wr_acc & hit_cmd & be[0];
   wire [7:0]  cmd     = wd[7:0];

   assign avs_waitrequest_o = bus_req & ~ack_ff;

   // ---------------------------------------------------------------
   // mode and command gating
   // ---------------------------------------------------------------
   assign fmode = par_prog_mode_i ? FM_PARALLEL :
                  ser_prog_mode_i ? FM_SERIAL   :
                  sel_ff          ? FM_REWRITE  : FM_NORMAL;

   wire prog_mode = (fmode == FM_PARALLEL) | (fmode == FM_SERIAL);
   wire busy      = (st_ff == ST_PRG_RD) | (st_ff == ST_PRG_CHK) |
                    (st_ff == ST_ERASE);
   wire cmd_mode_ok = fmode != FM_NORMAL;
   wire cmd_free    = (st_ff == ST_IDLE) & ~frst_ff & cmd_mode_ok;
   // user area open in every command mode, boot mode included
   wire area_ok   = ~addr_ff[16] | (fmode == FM_PARALLEL);
   wire erase_ok  = addr_ff[16] ? (addr_ff[15:0] == FBRC_BOOT_TOP)
                  : (addr_ff[15] & (addr_ff[12:0] == FBRC_USER_BLK_LAST));
   wire prog_ok   = addr_ff[16] ? (addr_ff[15:12] == FBRC_BOOT_PAGE)
                                : addr_ff[15];
   wire is_prog   = wr_cmd & (cmd == FBRC_CMD_PROGRAM) & cmd_free;
   wire is_erase  = wr_cmd & (cmd == FBRC_CMD_ERASE) & cmd_free;
   wire go_prog   = is_prog & area_ok & prog_ok;
   wire go_erase  = is_erase & area_ok & erase_ok;
   wire bad_prog  = is_prog & ~(area_ok & prog_ok);
   wire bad_erase = is_erase & ~(area_ok & erase_ok);
   wire go_clr    = wr_cmd & (cmd == FBRC_CMD_CLRSTAT) & cmd_mode_ok;
   wire pe_cmd    = wr_cmd & ((cmd == FBRC_CMD_PROGRAM) |
                              (cmd == FBRC_CMD_ERASE));
   wire ev_ref    = pe_cmd & ~(go_prog | go_erase);

   // ---------------------------------------------------------------
   // sequencer
   // ---------------------------------------------------------------
   // a bit can only go from one to zero when programming
   wire prog_fail = (st_ff == ST_PRG_CHK) & ~frst_ff &
                    ((mrdata & op_data_ff) != op_data_ff);
   wire [12:0] erase_last = op_boot_ff ? FBRC_BOOT_BLK_LAST
                                       : FBRC_USER_BLK_LAST;
   wire [15:0] er_addr = (op_addr_ff & ~{3'h0, erase_last}) |
                         {3'h0, cnt_ff};
   wire erase_end = (st_ff == ST_ERASE) & (cnt_ff == erase_last) & ~frst_ff;
   wire ev_done   = ((st_ff == ST_PRG_CHK) & ~frst_ff & ~prog_fail) |
                    erase_end;
   wire ev_perr   = prog_fail | bad_prog;
   wire ev_eerr   = bad_erase;
   // reads are refused in self-rewrite and under read-out protection in a programmer mode
   wire cpu_go    = cpu_rd_i & (st_ff == ST_IDLE) & ~sel_ff &
                    ~(prot_ff & prog_mode);
   wire cpu_boot  = boot_mode_ff & (cpu_addr_i[15:12] == FBRC_BOOT_PAGE);
   wire boot_pat  = strap_i.proc_mode_select_pin &
                    ~strap_i.boot_strap_pin &
                    strap_i.boot_chip_select_pin &
                    ~strap_i.boot_serial_clock_port &
                    strap_i.boot_serial_transmit_port;

   always_comb begin
      nxt_st  = st_ff;
      nxt_cnt = cnt_ff;
      mreq    = '0;
      case (st_ff)
         ST_STRAP: begin
            nxt_st = ST_VEC_LO;
         end
         ST_VEC_LO: begin
            mreq.re  = 1'b1;
            mreq.idx = fbrc_idx(boot_mode_ff, FBRC_VEC_LO);
            nxt_st   = ST_VEC_HI;
         end
         ST_VEC_HI: begin
            mreq.re  = 1'b1;
            mreq.idx = fbrc_idx(boot_mode_ff, FBRC_VEC_HI);
            nxt_st   = ST_VEC_END;
         end
         ST_VEC_END: begin
            nxt_st = ST_IDLE;
         end
         ST_IDLE: begin
            mreq.re  = cpu_go;
            mreq.idx = fbrc_idx(cpu_boot, cpu_addr_i);
            if (go_prog) begin
               nxt_st = ST_PRG_RD;
            end else if (go_erase) begin
               nxt_st  = ST_ERASE;
               nxt_cnt = 13'h0000;
            end
         end
         ST_PRG_RD: begin
            mreq.re  = 1'b1;
            mreq.idx = fbrc_idx(op_boot_ff, op_addr_ff);
            nxt_st   = ST_PRG_CHK;
         end
         ST_PRG_CHK: begin
            mreq.we    = ~prog_fail;
            mreq.idx   = fbrc_idx(op_boot_ff, op_addr_ff);
            mreq.wdata = op_data_ff;
            nxt_st     = ST_IDLE;
         end
         ST_ERASE: begin
            mreq.we    = 1'b1;
            mreq.idx   = fbrc_idx(op_boot_ff, er_addr);
            mreq.wdata = FBRC_ERASED;
            nxt_cnt    = cnt_ff + 13'h0001;
            if (erase_end) begin
               nxt_st = ST_IDLE;
            end
         end
         default: begin
            nxt_st = ST_IDLE;
         end
      endcase
      // held control circuit drops any operation in flight
      if (frst_ff && busy) begin
         nxt_st = ST_IDLE;
         mreq   = '0;
      end
   end

   fbrc_mem u_mem (
      .clk_i   (clk_i),
      .rst_b_i (rst_b_i),
      .req_i   (mreq),
      .rdata_o (mrdata)
   );

   // ---------------------------------------------------------------
   // sequencer state, straps and start vector
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_ff        <= ST_STRAP;
         cnt_ff       <= 13'h0000;
         boot_mode_ff <= 1'b0;
         vec_ff       <= 16'h0000;
         vec_valid_ff <= 1'b0;
      end else begin
         st_ff  <= nxt_st;
         cnt_ff <= nxt_cnt;
         if (st_ff == ST_STRAP) begin
            boot_mode_ff <= boot_pat;
         end
         if (st_ff == ST_VEC_HI) begin
            vec_ff[7:0] <= mrdata;
         end
         if (st_ff == ST_VEC_END) begin
            vec_ff[15:8] <= mrdata;
            vec_valid_ff <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         op_boot_ff <= 1'b0;
         op_addr_ff <= 16'h0000;
         op_data_ff <= 8'h00;
      end else if (go_prog || go_erase) begin
         op_boot_ff <= addr_ff[16];
         op_addr_ff <= addr_ff[15:0];
         op_data_ff <= data_ff;
      end
   end

   // ---------------------------------------------------------------
   // control register zero, status and software registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         armed_ff <= 1'b0;
         sel_ff   <= 1'b0;
         frst_ff  <= 1'b0;
         perr_ff  <= 1'b0;
         eerr_ff  <= 1'b0;
      end else begin
         if (wr_acc) begin
            armed_ff <= wr_c0 & ~wd[FBRC_C0_SEL];
         end
         if (wr_c0) begin
            // works the same from single-chip and boot mode
            sel_ff  <= wd[FBRC_C0_SEL] & (sel_ff | armed_ff);
            frst_ff <= wd[FBRC_C0_FRST] & sel_ff;
         end
         perr_ff <= ev_perr | (perr_ff & ~go_clr);
         eerr_ff <= ev_eerr | (eerr_ff & ~go_clr);
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         addr_ff   <= 17'h00000;
         data_ff   <= 8'h00;
         prot_ff   <= 1'b0;
         irq_en_ff <= '0;
         irq_st_ff <= '0;
      end else begin
         if (wr_acc && hit_adr && be[0]) addr_ff[7:0]  <= wd[7:0];
         if (wr_acc && hit_adr && be[1]) addr_ff[15:8] <= wd[15:8];
         if (wr_acc && hit_adr && be[2]) addr_ff[16]   <= wd[16];
         if (wr_acc && hit_dat && be[0]) data_ff       <= wd[7:0];
         if (wr_acc && hit_md && be[0] && prog_mode) begin
            prot_ff <= wd[FBRC_MD_PROT];
         end
         if (wr_acc && hit_ien && be[0]) begin
            irq_en_ff <= wd[FBRC_IRQ_W-1:0];
         end
         // a new event wins over a clear in the same cycle
         irq_st_ff <= (irq_st_ff &
                       ~((wr_acc && hit_icl && be[0]) ?
                         wd[FBRC_IRQ_W-1:0] : '0)) |
                      {ev_ref, ev_eerr, ev_perr, ev_done};
      end
   end

   // ---------------------------------------------------------------
   // read back
   // ---------------------------------------------------------------
   wire [31:0] c0_val = {24'h000000, eerr_ff, perr_ff, 2'b00, frst_ff,
                         1'b0, sel_ff, ~busy};
   wire [31:0] md_val = {vec_ff, 11'h000, vec_valid_ff, prot_ff,
                         ser_prog_mode_i, par_prog_mode_i, boot_mode_ff};
   wire [31:0] rd_mux =
      hit_c0  ? c0_val :
      hit_adr ? {15'h0000, addr_ff} :
      hit_dat ? {24'h000000, data_ff} :
      hit_md  ? md_val :
      hit_ist ? {28'h0000000, irq_st_ff} :
      hit_ien ? {28'h0000000, irq_en_ff} : 32'h00000000;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ack_ff   <= 1'b0;
         rdata_ff <= 32'h00000000;
      end else begin
         ack_ff <= bus_req & ~ack_ff;
         if (rd_go) rdata_ff <= rd_mux;
      end
   end

   // ---------------------------------------------------------------
   // cpu array read port: two cycle answer, error when refused
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cpu_pend_ff  <= 1'b0;
         cpu_epend_ff <= 1'b0;
         cpu_ack_ff   <= 1'b0;
         cpu_err_ff   <= 1'b0;
         cpu_rdata_ff <= 8'h00;
      end else begin
         cpu_pend_ff  <= cpu_go;
         cpu_epend_ff <= cpu_rd_i & ~cpu_go;
         cpu_ack_ff   <= cpu_pend_ff | cpu_epend_ff;
         cpu_err_ff   <= cpu_epend_ff;
         cpu_rdata_ff <= cpu_pend_ff ? mrdata : 8'h00;
      end
   end

   assign avs_readdata_o     = rdata_ff;
   assign cpu_ack_o          = cpu_ack_ff;
   assign cpu_rdata_o        = cpu_rdata_ff;
   assign cpu_rd_err_o       = cpu_err_ff;
   assign boot_mode_o        = boot_mode_ff;
   assign start_vec_o        = vec_ff;
   assign start_vec_valid_o  = vec_valid_ff;
   assign flash_ready_flag_o = ~busy;
   assign irq_o              = |(irq_st_ff & irq_en_ff);

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   logic [13:0] er_cyc_ff;
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) er_cyc_ff <= 14'h0000;
      // counted from the accept, independent of the sequencer counter
      else er_cyc_ff <= go_erase ? 14'h0001 :
                        busy     ? er_cyc_ff + 14'h0001 : 14'h0000;
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);

   sequence s_prog_run;
      (!flash_ready_flag_o)[*2] ##1 flash_ready_flag_o;
   endsequence
   sequence s_vec;
      (mreq.re && mreq.idx == fbrc_idx(boot_mode_ff, FBRC_VEC_LO)) ##1
      (mreq.re && mreq.idx == fbrc_idx(boot_mode_ff, FBRC_VEC_HI)) ##2
      start_vec_valid_o;
   endsequence

   chk_prog_busy :
   assert property (go_prog |=> s_prog_run)
      else $error("program busy window wrong");
   chk_sel_arm :
   assert property ($rose(sel_ff) |-> $past(armed_ff) && $past(wr_c0))
      else $error("select bit set without zero then one");
   chk_sel_clear :
   assert property (wr_c0 && !wd[FBRC_C0_SEL] |=> !sel_ff &&
                    fmode != FM_REWRITE)
      else $error("select bit not cleared by zero write");
   chk_boot_guard :
   assert property (mreq.we && mreq.idx >= FBRC_BOOT_IDX_BASE
                    |-> fmode == FM_PARALLEL)
      else $error("boot area written outside parallel mode");
   chk_frst_abort :
   assert property (frst_ff && busy |=> st_ff == ST_IDLE && !mreq.we)
      else $error("flash reset did not stop operation");
   chk_cmd_gate :
   assert property ($fell(flash_ready_flag_o) |-> $past(fmode) != FM_NORMAL)
      else $error("operation started outside command mode");
   chk_cpu_block :
   assert property (cpu_rd_i && sel_ff |-> ##2 cpu_ack_o && cpu_rd_err_o)
      else $error("array read allowed in self-rewrite");
   chk_erase_len :
   assert property (erase_end |->
                    er_cyc_ff == {1'b0, erase_last} + 14'h0001)
      else $error("erase length wrong");
   chk_vec_fetch :
   assert property (st_ff == ST_VEC_LO |-> s_vec)
      else $error("start vector fetch wrong");
   chk_perr_set :
   assert property (prog_fail |=> perr_ff && irq_st_ff[FBRC_IRQ_PERR])
      else $error("program failure not flagged");

endmodule : fbrc_ctrl

/* hw/fbrc_mem.sv */
`timescale 1ns/1ps
module fbrc_mem
   import fbrc_pkg::*;
(
   input  wire logic           clk_i,
   input  wire logic           rst_b_i,
   input  wire fbrc_mem_req_t  req_i,
   output logic [7:0]          rdata_o
);

   logic [7:0] mem [FBRC_MEM_DEPTH];
   logic [7:0] rdata_ff;

   // ---------------------------------------------------------------
   // array starts erased, as a blank part would
   // ---------------------------------------------------------------
   initial begin
      for (int i = 0; i < FBRC_MEM_DEPTH; i++) begin
         mem[i] = FBRC_ERASED;
      end
   end

   always @(posedge clk_i) begin
      if (req_i.we) begin
         mem[req_i.idx] <= req_i.wdata;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rdata_ff <= 8'h00;
      end else if (req_i.re) begin
         rdata_ff <= mem[req_i.idx];
      end
   end

   assign rdata_o = rdata_ff;

endmodule : fbrc_mem

/* hw/fbrc_pkg.sv */
package fbrc_pkg;

   // ---------------------------------------------------------------
   // register map (byte addresses on the register bus)
   // ---------------------------------------------------------------
   localparam logic [11:0] FBRC_OFS_CTRL0   = 12'hfe0;
   localparam logic [11:0] FBRC_OFS_CMD     = 12'hfe4;
   localparam logic [11:0] FBRC_OFS_ADDR    = 12'hfe8;
   localparam logic [11:0] FBRC_OFS_DATA    = 12'hfec;
   localparam logic [11:0] FBRC_OFS_MODE    = 12'hff0;
   localparam logic [11:0] FBRC_OFS_IRQ_ST  = 12'hff4;
   localparam logic [11:0] FBRC_OFS_IRQ_EN  = 12'hff8;
   localparam logic [11:0] FBRC_OFS_IRQ_CLR = 12'hffc;

   // flash_control_reg_zero fields
   localparam int unsigned FBRC_C0_READY = 0;
   localparam int unsigned FBRC_C0_SEL   = 1;
   localparam int unsigned FBRC_C0_FRST  = 3;
   localparam int unsigned FBRC_C0_PERR  = 6;
   localparam int unsigned FBRC_C0_EERR  = 7;

   // mode register fields
   localparam int unsigned FBRC_MD_BOOT  = 0;
   localparam int unsigned FBRC_MD_PAR   = 1;
   localparam int unsigned FBRC_MD_SER   = 2;
   localparam int unsigned FBRC_MD_PROT  = 3;
   localparam int unsigned FBRC_MD_VECV  = 4;
   localparam int unsigned FBRC_MD_VEC   = 16;

   // interrupt status / enable / clear fields
   localparam int unsigned FBRC_IRQ_W    = 4;
   localparam int unsigned FBRC_IRQ_DONE = 0;
   localparam int unsigned FBRC_IRQ_PERR = 1;
   localparam int unsigned FBRC_IRQ_EERR = 2;
   localparam int unsigned FBRC_IRQ_REF  = 3;

   // ---------------------------------------------------------------
   // software commands
   // ---------------------------------------------------------------
   localparam logic [7:0] FBRC_CMD_PROGRAM = 8'h40;
   localparam logic [7:0] FBRC_CMD_ERASE   = 8'h20;
   localparam logic [7:0] FBRC_CMD_CLRSTAT = 8'h50;

   // ---------------------------------------------------------------
   // array layout
   // ---------------------------------------------------------------
   localparam int unsigned FBRC_MEM_DEPTH     = 36864;
   localparam logic [15:0] FBRC_BOOT_IDX_BASE = 16'h8000;
   localparam logic [15:0] FBRC_BOOT_TOP      = 16'hffff;
   localparam logic [3:0]  FBRC_BOOT_PAGE     = 4'hf;
   localparam logic [12:0] FBRC_USER_BLK_LAST = 13'h1fff;
   localparam logic [12:0] FBRC_BOOT_BLK_LAST = 13'h0fff;
   localparam logic [15:0] FBRC_VEC_LO        = 16'hfffc;
   localparam logic [15:0] FBRC_VEC_HI        = 16'hfffd;
   localparam logic [7:0]  FBRC_ERASED        = 8'hff;

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_STRAP, ST_VEC_LO, ST_VEC_HI, ST_VEC_END,
      ST_IDLE, ST_PRG_RD, ST_PRG_CHK, ST_ERASE
   } fbrc_state_t;

   typedef enum logic [1:0] {
      FM_NORMAL, FM_REWRITE, FM_SERIAL, FM_PARALLEL
   } fbrc_fmode_t;

   typedef struct packed {
      logic proc_mode_select_pin;
      logic boot_strap_pin;
      logic boot_chip_select_pin;
      logic boot_serial_clock_port;
      logic boot_serial_transmit_port;
   } fbrc_strap_t;

   typedef struct packed {
      logic        we;
      logic        re;
      logic [15:0] idx;
      logic [7:0]  wdata;
   } fbrc_mem_req_t;

   // user area 8000..ffff maps to 0..7fff, boot area f000..ffff after it
   function automatic logic [15:0] fbrc_idx(input logic        boot,
                                            input logic [15:0] a);
      fbrc_idx = boot ? (FBRC_BOOT_IDX_BASE | {4'h0, a[11:0]})
                      : {1'b0, a[14:0]};
   endfunction : fbrc_idx

endpackage : fbrc_pkg

/* tb/fbrc_cpu_model.sv */
`timescale 1ns/1ps
// ----------------------------
// cpu read port driver
// ----------------------------
module fbrc_cpu_model (
   input  wire logic        clk_i,
   input  wire logic        go_i,
   input  wire logic [15:0] addr_i,
   output logic             rd_o,
   output logic [15:0]      addr_o
);
   initial begin
      rd_o = 1'b0;
      addr_o = 16'h0000;
   end
   // address flips when idle so a stale value never passes
   always @(posedge clk_i) begin
      rd_o <= go_i;
      addr_o <= go_i ? addr_i : ~addr_o;
   end
endmodule : fbrc_cpu_model

/* tb/flash_boot_and_rewrite_control_test.sv */
`timescale 1ns/1ps
// ----------------------------
// flash control bench
// ----------------------------
module flash_boot_and_rewrite_control_test;
   import fbrc_pkg::*;
   localparam int LIM = 9000;
   logic clk_i = 0, rst_b_i = 0, rd = 0, wr = 0, go = 0, crd;
   logic par = 0, ser = 0;
   logic ack, cerr, bootm, vecv, rdy, irq, wq;
   logic [11:0] adr = 0;
   logic [31:0] wd = 0, rdat, q;
   logic [15:0] ca = 0, cadr, vec;
   logic [7:0] cdat;
   fbrc_strap_t strap = '0;
   int miscompares = 0, checked = 0;
   always #12.5 clk_i = ~clk_i;
   fbrc_ctrl fbrc_ctrl_i (.clk_i(clk_i), .rst_b_i(rst_b_i),
      .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
      .avs_writedata_i(wd), .avs_byteenable_i(4'hf),
      .avs_readdata_o(rdat), .avs_waitrequest_o(wq), .strap_i(strap),
      .par_prog_mode_i(par), .ser_prog_mode_i(ser), .cpu_rd_i(crd),
      .cpu_addr_i(cadr), .cpu_ack_o(ack), .cpu_rdata_o(cdat),
      .cpu_rd_err_o(cerr), .boot_mode_o(bootm), .start_vec_o(vec),
      .start_vec_valid_o(vecv), .flash_ready_flag_o(rdy), .irq_o(irq));
   fbrc_cpu_model fbrc_cpu_model_i (.clk_i(clk_i), .go_i(go),
      .addr_i(ca), .rd_o(crd), .addr_o(cadr));
   task conclude;
      if (miscompares == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : conclude
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         miscompares++;
         $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
      end
   endtask : cmp
   task automatic bound(input int n);
      if (n >= LIM) begin
         miscompares++;
         conclude();
      end
   endtask : bound
   // waitrequest looked at on rising edges; data taken at the accept edge
   task automatic bus(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      adr <= a;
      wd <= d;
      wr <= w;
      rd <= !w;
      do begin @(posedge clk_i); n++; end while (wq !== 1'b0 && n < LIM);
      bound(n);
      q = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask : bus
   task automatic reg_is(input logic [11:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      cmp(q, e);
   endtask : reg_is
   task automatic wait_rdy;
      int n;
      n = 0;
      do begin @(negedge clk_i); n++; end while (rdy !== 1'b1 && n < LIM);
      bound(n);
   endtask : wait_rdy
   task automatic cmd(input logic [16:0] a, input logic [7:0] c);
      bus(1'b1, FBRC_OFS_ADDR, {15'h0, a});
      bus(1'b1, FBRC_OFS_CMD, {24'h0, c});
      wait_rdy();
   endtask : cmd
   task automatic cpu_read(input logic [15:0] a, input logic [7:0] e,
                           input logic ee);
      int n;
      n = 0;
      @(posedge clk_i);
      go <= 1'b1;
      ca <= a;
      @(posedge clk_i);
      go <= 1'b0;
      do begin @(negedge clk_i); n++; end while (ack !== 1'b1 && n < LIM);
      bound(n);
      cmp(cdat, e);
      cmp(cerr, ee);
   endtask : cpu_read
   task automatic reset_to(input fbrc_strap_t s);
      @(posedge clk_i);
      strap <= s;
      rst_b_i <= 1'b0;
      repeat (12) @(posedge clk_i);
      rst_b_i <= 1'b1;
      repeat (6) @(posedge clk_i);
   endtask : reset_to
   task automatic rewrite_on;
      bus(1'b1, FBRC_OFS_CTRL0, 32'h0);
      bus(1'b1, FBRC_OFS_CTRL0, 32'h2);
   endtask : rewrite_on
   task automatic sc_select;
      cmp(bootm, 1'b0);
      bus(1'b1, FBRC_OFS_CTRL0, 32'h2);
      reg_is(FBRC_OFS_CTRL0, 32'h1);
      rewrite_on();
      reg_is(FBRC_OFS_CTRL0, 32'h3);
      cpu_read(16'h8000, 8'h00, 1'b1);
   endtask : sc_select
   task automatic sc_program;
      bus(1'b1, FBRC_OFS_DATA, 32'h5a);
      cmd(17'h08000, FBRC_CMD_PROGRAM);
      reg_is(FBRC_OFS_CTRL0, 32'h3);
      bus(1'b1, FBRC_OFS_DATA, 32'ha5);
      cmd(17'h08000, FBRC_CMD_PROGRAM);
      reg_is(FBRC_OFS_CTRL0, 32'h43);
      bus(1'b1, FBRC_OFS_IRQ_EN, 32'h2);
      @(negedge clk_i);
      cmp(irq, 1'b1);
      bus(1'b1, FBRC_OFS_IRQ_CLR, 32'h2);
      @(negedge clk_i);
      cmp(irq, 1'b0);
   endtask : sc_program
   task automatic sc_refuse;
      cmd(17'h08000, FBRC_CMD_CLRSTAT);
      cmd(17'h1ffff, FBRC_CMD_ERASE);
      reg_is(FBRC_OFS_CTRL0, 32'h83);
      cmd(17'h08000, FBRC_CMD_CLRSTAT);
      cmd(17'h08000, FBRC_CMD_ERASE);
      reg_is(FBRC_OFS_CTRL0, 32'h83);
      bus(1'b1, FBRC_OFS_CTRL0, 32'h0);
      reg_is(FBRC_OFS_CTRL0, 32'h81);
      cpu_read(16'h8000, 8'h5a, 1'b0);
   endtask : sc_refuse
   task automatic sc_boot;
      reset_to(5'b10101);
      cmp(bootm, 1'b1);
      cmp({vecv, vec}, 17'h1ffff);
      rewrite_on();
      reg_is(FBRC_OFS_CTRL0, 32'h3);
      bus(1'b1, FBRC_OFS_DATA, 32'h3c);
      cmd(17'h09ffe, FBRC_CMD_PROGRAM);
      bus(1'b1, FBRC_OFS_CTRL0, 32'h0);
      cpu_read(16'h9ffe, 8'h3c, 1'b0);
   endtask : sc_boot
   // held control circuit cuts an erase, then a full block erase
   task automatic sc_erase;
      rewrite_on();
      bus(1'b1, FBRC_OFS_ADDR, 32'h09fff);
      bus(1'b1, FBRC_OFS_CMD, {24'h0, FBRC_CMD_ERASE});
      @(negedge clk_i);
      cmp(rdy, 1'b0);
      bus(1'b1, FBRC_OFS_CTRL0, 32'ha);
      reg_is(FBRC_OFS_CTRL0, 32'hb);
      bus(1'b1, FBRC_OFS_CTRL0, 32'h2);
      cmd(17'h09fff, FBRC_CMD_ERASE);
      reg_is(FBRC_OFS_CTRL0, 32'h3);
      bus(1'b1, FBRC_OFS_CTRL0, 32'h0);
      cpu_read(16'h9ffe, 8'hff, 1'b0);
   endtask : sc_erase
   task automatic sc_parallel;
      @(posedge clk_i);
      par <= 1'b1;
      bus(1'b1, FBRC_OFS_MODE, 32'h8);
      cpu_read(16'h8000, 8'h00, 1'b1);
      @(posedge clk_i);
      par <= 1'b0;
      ser <= 1'b1;
      cpu_read(16'h8000, 8'h00, 1'b1);
      bus(1'b1, FBRC_OFS_MODE, 32'h0);
      @(posedge clk_i);
      ser <= 1'b0;
      par <= 1'b1;
      cmd(17'h1ffff, FBRC_CMD_ERASE);
      bus(1'b1, FBRC_OFS_DATA, 32'h12);
      cmd(17'h1fffc, FBRC_CMD_PROGRAM);
      reg_is(FBRC_OFS_CTRL0, 32'h1);
      cpu_read(16'hfffc, 8'h12, 1'b0);
      @(posedge clk_i);
      par <= 1'b0;
      reset_to(5'b10101);
      cmp({vecv, vec}, 17'h1ff12);
   endtask : sc_parallel
   initial begin
      reset_to(5'b00000);
      sc_select();
      sc_program();
      sc_refuse();
      sc_boot();
      sc_erase();
      sc_parallel();
      conclude();
   end
endmodule : flash_boot_and_rewrite_control_test
